/* mts_sequencer.sv */
// Purpose: trigger sequencer with APB registers, delay, counts and reading memory
// Assumes: sample engine on pclk answers sample_req with one sample_valid pulse
// Notes: ext_trig_in is asynchronous and synchronised here
`timescale 1ns/100ps
`include "mts_params.svh"
// Functional notes
// - triggers accepted in wait-for-trigger state, and in idle under local operation
// - ignore external triggers 20 ms after arming
// - configure_and_query_a, read and store-arm all arm sequencer
// - store-arm readings go to 1024-entry memory
// - read query readings go straight to output
// - fetch moves stored readings to output buffer
// - source bus, immediate or external; immediate default
// - programmable trigger delay, zero to 3600 s
// - auto delay from settings; delay write clears it
// - sample count per trigger 1 to 50000
// - trigger count 1 to 50000, then idle
// - infinite count until device clear; special report
// - local operation disregards trigger count
// - local operation always armed unless measuring or fetching
// - source query returns bus, immediate or external code
// - reset command restores power-on settings
// - read mode: message flag at first reading
// - store then fetch: flag only after completion
module mts_sequencer #(
	parameter int TICK_CYC = `MTS_TICK_CYC,
	parameter int SETUP_MS = `MTS_SETUP_MS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_trig_in,
	output logic sample_req,
	input wire logic sample_valid,
	input wire logic [31:0] sample_data,
	output logic message_available_flag,
	output logic measuring
);
	localparam int MAW = $clog2(`MTS_MEM_DEPTH);
	mts_pkg::mts_state_t state_r;
	mts_pkg::mts_src_t src_r;
	mts_pkg::mts_cfg_t cfg_r;
	logic [21:0] delay_r;
	logic [15:0] scount_r;
	logic [15:0] tcount_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic [31:0] tick_cnt_r;
	logic tick;
	logic [7:0] setup_cnt_r;
	logic [21:0] dly_cnt_r;
	logic [15:0] samp_done_r;
	logic [15:0] trig_done_r;
	logic store_mode_r;
	logic req_pend_r;
	logic fetch_r;
	logic [2:0] ext_sync_r;
	logic ext_rise;
	logic wr_en;
	logic rd_en;
	logic [6:0] cmd;
	logic trig_ok;
	logic trig_hit;
	logic arm;
	logic [21:0] eff_delay;
	mts_pkg::mts_rdg_t out_r;
	mts_pkg::mts_rdg_t mem_wr;
	logic mem_pop;
	logic [31:0] mem_rd_data;
	logic mem_avail;
	logic mem_full;
	logic [MAW:0] mem_count;

	function automatic logic [15:0] clamp_count(input logic [31:0] v);
		if (v < 32'(`MTS_COUNT_MIN)) begin
			return 16'(`MTS_COUNT_MIN);
		end else if (v > 32'(`MTS_COUNT_MAX)) begin
			return 16'(`MTS_COUNT_MAX);
		end
		return v[15:0];
	endfunction

	function automatic logic [21:0] auto_delay_ms(input mts_pkg::mts_cfg_t c);
		logic [21:0] d;
		d = 22'(`MTS_AUTO_BASE_MS) << c.nplc;
		d = d + 22'(c.rng) + 22'(c.func);
		if (c.filt) begin
			d = d + 22'(`MTS_AUTO_FILT_MS);
		end
		return d;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		case (a)
			`MTS_OFF_CMD, `MTS_OFF_CFG, `MTS_OFF_DELAY, `MTS_OFF_SCOUNT,
			`MTS_OFF_TCOUNT, `MTS_OFF_STATUS, `MTS_OFF_DATA: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// apb: zero wait states, read data captured in setup
	assign pready = 1'b1;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
	assign wr_en = psel && penable && pwrite && mapped(paddr) && (pstrb == 4'hf);
	assign rd_en = psel && penable && !pwrite && mapped(paddr);
	assign cmd = (wr_en && paddr == `MTS_OFF_CMD) ? pwdata[6:0] : 7'h00;
	assign arm = state_r == mts_pkg::MTS_IDLE &&
		(cmd[`MTS_CMD_STORE] || cmd[`MTS_CMD_READ] || cmd[`MTS_CMD_MEAS]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (psel && !penable) begin
			pslverr_r <= !mapped(paddr) || (pwrite && pstrb != 4'hf);
			case (paddr)
				`MTS_OFF_CFG: prdata_r <= {19'h0_0000, cfg_r.auto_dly, cfg_r[11:2], src_r};
				`MTS_OFF_DELAY: prdata_r <= {10'h000, cfg_r.auto_dly ? auto_delay_ms(cfg_r) : delay_r};
				`MTS_OFF_SCOUNT: prdata_r <= {16'h0000, scount_r};
				`MTS_OFF_TCOUNT: prdata_r <= cfg_r.count_inf ? `MTS_INF_REPORT : {16'h0000, tcount_r};
				`MTS_OFF_STATUS: prdata_r <= {12'h000, 6'(mem_count), 6'h00, message_available_flag,
					out_r.valid, src_r, state_r};
				`MTS_OFF_DATA: prdata_r <= out_r.data;
				default: prdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// settings; reset command restores power-on values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_r <= mts_pkg::MTS_SRC_IMM;
			cfg_r <= `MTS_CFG_RESET;
			delay_r <= `MTS_DELAY_RESET;
			scount_r <= `MTS_COUNT_RESET;
			tcount_r <= `MTS_COUNT_RESET;
		end else if (cmd[`MTS_CMD_RST]) begin
			src_r <= mts_pkg::MTS_SRC_IMM;
			cfg_r <= `MTS_CFG_RESET;
			delay_r <= `MTS_DELAY_RESET;
			scount_r <= `MTS_COUNT_RESET;
			tcount_r <= `MTS_COUNT_RESET;
		end else if (wr_en) begin
			case (paddr)
				`MTS_OFF_CFG: begin
					src_r <= (pwdata[1:0] == 2'h3) ? src_r : mts_pkg::mts_src_t'(pwdata[1:0]);
					cfg_r <= {pwdata[11:2], pwdata[12], 1'b0};
				end
				`MTS_OFF_DELAY: begin
					delay_r <= (pwdata > 32'(`MTS_DELAY_MAX_MS)) ? 22'(`MTS_DELAY_MAX_MS) : pwdata[21:0];
					cfg_r.auto_dly <= 1'b0;
				end
				`MTS_OFF_SCOUNT: scount_r <= clamp_count(pwdata);
				`MTS_OFF_TCOUNT: tcount_r <= clamp_count(pwdata);
				default: ;
			endcase
		end
	end

	// millisecond tick
	assign tick = (tick_cnt_r == 32'(TICK_CYC - 1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_r <= 32'h0000_0000;
		end else if (tick) begin
			tick_cnt_r <= 32'h0000_0000;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
		end
	end

	// external trigger: two-flop sync then rising edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_sync_r <= 3'h0;
		end else begin
			ext_sync_r <= {ext_sync_r[1:0], ext_trig_in};
		end
	end
	assign ext_rise = ext_sync_r[1] && !ext_sync_r[2];

	// set-up window after arming
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			setup_cnt_r <= 8'h00;
		end else if (arm) begin
			setup_cnt_r <= 8'(SETUP_MS) + 8'h01;
		end else if (tick && setup_cnt_r != 8'h00) begin
			setup_cnt_r <= setup_cnt_r - 8'h01;
		end
	end

	always_comb begin
		case (src_r)
			mts_pkg::MTS_SRC_IMM: trig_hit = 1'b1;
			mts_pkg::MTS_SRC_BUS: trig_hit = cmd[`MTS_CMD_BUSTRG];
			mts_pkg::MTS_SRC_EXT: trig_hit = ext_rise && setup_cnt_r == 8'h00;
			default: trig_hit = 1'b0;
		endcase
	end
	assign trig_ok = trig_hit && (state_r == mts_pkg::MTS_WAIT ||
		(cfg_r.local_op && state_r == mts_pkg::MTS_IDLE && !fetch_r));
	assign eff_delay = cfg_r.auto_dly ? auto_delay_ms(cfg_r) : delay_r;
	assign measuring = state_r == mts_pkg::MTS_DELAY || state_r == mts_pkg::MTS_SAMPLE;

	// sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= mts_pkg::MTS_IDLE;
		end else if (cmd[`MTS_CMD_DCL] || cmd[`MTS_CMD_RST]) begin
			state_r <= mts_pkg::MTS_IDLE;
		end else begin
			case (state_r)
				mts_pkg::MTS_IDLE: begin
					if (trig_ok) begin
						state_r <= mts_pkg::MTS_DELAY;
					end else if (arm) begin
						state_r <= mts_pkg::MTS_WAIT;
					end
				end
				mts_pkg::MTS_WAIT: begin
					if (trig_ok) begin
						state_r <= mts_pkg::MTS_DELAY;
					end
				end
				mts_pkg::MTS_DELAY: begin
					if (dly_cnt_r >= eff_delay) begin
						state_r <= mts_pkg::MTS_SAMPLE;
					end
				end
				mts_pkg::MTS_SAMPLE: begin
					if (sample_valid && samp_done_r + 16'h0001 >= scount_r) begin
						if (cfg_r.local_op) begin
							state_r <= mts_pkg::MTS_IDLE;
						end else if (!cfg_r.count_inf && trig_done_r + 16'h0001 >= tcount_r) begin
							state_r <= mts_pkg::MTS_IDLE;
						end else begin
							state_r <= mts_pkg::MTS_WAIT;
						end
					end else if (sample_valid) begin
						state_r <= mts_pkg::MTS_DELAY;
					end
				end
				default: state_r <= mts_pkg::MTS_IDLE;
			endcase
		end
	end

	// delay timer in milliseconds
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly_cnt_r <= 22'h00_0000;
		end else if (state_r != mts_pkg::MTS_DELAY) begin
			dly_cnt_r <= 22'h00_0000;
		end else if (tick) begin
			dly_cnt_r <= dly_cnt_r + 22'h00_0001;
		end
	end

	// sample and trigger counters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			samp_done_r <= 16'h0000;
			trig_done_r <= 16'h0000;
		end else if (arm || (state_r == mts_pkg::MTS_IDLE && trig_ok)) begin
			samp_done_r <= 16'h0000;
			trig_done_r <= 16'h0000;
		end else if (state_r == mts_pkg::MTS_SAMPLE && sample_valid) begin
			if (samp_done_r + 16'h0001 >= scount_r) begin
				samp_done_r <= 16'h0000;
				trig_done_r <= trig_done_r + 16'h0001;
			end else begin
				samp_done_r <= samp_done_r + 16'h0001;
			end
		end
	end

	// one request per sample; outside store mode stalls while output buffer holds data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_pend_r <= 1'b0;
		end else if (state_r != mts_pkg::MTS_SAMPLE || sample_valid) begin
			req_pend_r <= 1'b0;
		end else if (sample_req) begin
			req_pend_r <= 1'b1;
		end
	end
	assign sample_req = state_r == mts_pkg::MTS_SAMPLE && !req_pend_r && (store_mode_r || !out_r.valid);

	// destination of readings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			store_mode_r <= 1'b0;
		end else if (arm) begin
			store_mode_r <= cmd[`MTS_CMD_STORE];
		end else if (state_r == mts_pkg::MTS_IDLE && trig_ok) begin
			store_mode_r <= 1'b0;
		end
	end

	assign mem_wr.valid = store_mode_r && state_r == mts_pkg::MTS_SAMPLE && sample_valid && !mem_full;
	assign mem_wr.data = sample_data;

	// fetch runs while memory has data and the run is finished
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fetch_r <= 1'b0;
		end else if (cmd[`MTS_CMD_DCL] || cmd[`MTS_CMD_RST] || arm) begin
			fetch_r <= 1'b0;
		end else if (cmd[`MTS_CMD_FETCH] && state_r == mts_pkg::MTS_IDLE && mem_avail) begin
			fetch_r <= 1'b1;
		end else if (!mem_avail) begin
			fetch_r <= 1'b0;
		end
	end
	assign mem_pop = fetch_r && !out_r.valid;

	// output buffer word; a data read empties it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_r <= '0;
		end else if (cmd[`MTS_CMD_DCL] || cmd[`MTS_CMD_RST] || arm) begin
			out_r.valid <= 1'b0;
		end else if (!store_mode_r && state_r == mts_pkg::MTS_SAMPLE && sample_valid) begin
			out_r <= {1'b1, sample_data};
		end else if (mem_pop && mem_avail) begin
			out_r <= {1'b1, mem_rd_data};
		end else if (rd_en && paddr == `MTS_OFF_DATA) begin
			out_r.valid <= 1'b0;
		end
	end

	// message flag: set by a reading in the buffer, cleared once all is read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			message_available_flag <= 1'b0;
		end else if (out_r.valid) begin
			message_available_flag <= 1'b1;
		end else if (!fetch_r && (store_mode_r || state_r == mts_pkg::MTS_IDLE)) begin
			message_available_flag <= 1'b0;
		end
	end

	mts_reading_mem #(
		.DEPTH(`MTS_MEM_DEPTH),
		.AW(MAW)
	) u_mem (
		.pclk(pclk),
		.presetn(presetn),
		.clear(arm && cmd[`MTS_CMD_STORE]),
		.wr(mem_wr),
		.rd_pop(mem_pop),
		.rd_data(mem_rd_data),
		.rd_avail(mem_avail),
		.full(mem_full),
		.count(mem_count)
	);
endmodule // mts_sequencer

/* mts_params.svh */
// Purpose: constants of the measurement trigger sequencer
// Assumes: pclk at 25 MHz, 32-bit APB
// Notes: byte offsets, field positions, reset values and times
`ifndef MTS_PARAMS_SVH
`define MTS_PARAMS_SVH
`define MTS_CLK_HZ 25000000
`define MTS_MS_PER_S 1000
`define MTS_TICK_CYC (`MTS_CLK_HZ / `MTS_MS_PER_S)
`define MTS_SETUP_MS 20
`define MTS_DELAY_MAX_S 3600
`define MTS_DELAY_MAX_MS (`MTS_DELAY_MAX_S * `MTS_MS_PER_S)
`define MTS_COUNT_MIN 1
`define MTS_COUNT_MAX 50000
`define MTS_MEM_DEPTH 1024
`define MTS_INF_REPORT 32'h7e94_f57c
`define MTS_AUTO_BASE_MS 1
`define MTS_AUTO_FILT_MS 100
`define MTS_OFF_CMD 8'h00
`define MTS_OFF_CFG 8'h04
`define MTS_OFF_DELAY 8'h08
`define MTS_OFF_SCOUNT 8'h0c
`define MTS_OFF_TCOUNT 8'h10
`define MTS_OFF_STATUS 8'h14
`define MTS_OFF_DATA 8'h18
`define MTS_CMD_STORE 0
`define MTS_CMD_READ 1
`define MTS_CMD_MEAS 2
`define MTS_CMD_FETCH 3
`define MTS_CMD_DCL 4
`define MTS_CMD_RST 5
`define MTS_CMD_BUSTRG 6
`define MTS_CFG_W 12
`define MTS_CFG_RESET 12'h000
`define MTS_DELAY_RESET 22'h00_0000
`define MTS_COUNT_RESET 16'h0001
`endif

/* mts_pkg.sv */
// Purpose: types of the measurement trigger sequencer
// Assumes: constants live in mts_params.svh
// Notes: cfg bits 11:2 are config register bits 11:2; auto_dly is register bit 12
package mts_pkg;
	typedef enum logic [3:0] {
		MTS_IDLE = 4'b0001,
		MTS_WAIT = 4'b0010,
		MTS_DELAY = 4'b0100,
		MTS_SAMPLE = 4'b1000
	} mts_state_t;
	typedef enum logic [1:0] {
		MTS_SRC_IMM = 2'h0,
		MTS_SRC_BUS = 2'h1,
		MTS_SRC_EXT = 2'h2
	} mts_src_t;
	typedef struct packed {
		logic filt;
		logic [1:0] nplc;
		logic [2:0] rng;
		logic [1:0] func;
		logic local_op;
		logic count_inf;
		logic auto_dly;
		logic src_hi;
	} mts_cfg_t;
	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} mts_rdg_t;
endpackage

/* mts_reading_mem.sv */
// Purpose: internal reading memory of the trigger sequencer
// Assumes: one writer, one sequential reader, same clock
// Notes: writes beyond depth are dropped, never wrap
`timescale 1ns/100ps
`include "mts_params.svh"
module mts_reading_mem #(
	parameter int DEPTH = `MTS_MEM_DEPTH,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire mts_pkg::mts_rdg_t wr,
	input wire logic rd_pop,
	output logic [31:0] rd_data,
	output logic rd_avail,
	output logic full,
	output logic [AW:0] count
);
	logic [31:0] mem [DEPTH];
	logic [AW:0] rd_ptr_r;
	assign full = (count == (AW+1)'(DEPTH));
	assign rd_avail = (rd_ptr_r != count);
	assign rd_data = mem[rd_ptr_r[AW-1:0]];
	always_ff @(posedge pclk) begin
		if (wr.valid && !full && !clear) begin
			mem[count[AW-1:0]] <= wr.data;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else if (clear) begin
			count <= '0;
		end else if (wr.valid && !full) begin
			count <= count + 1'b1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_ptr_r <= '0;
		end else if (clear) begin
			rd_ptr_r <= '0;
		end else if (rd_pop && rd_avail) begin
			rd_ptr_r <= rd_ptr_r + 1'b1;
		end
	end
endmodule // mts_reading_mem

/* mts_sequencer_chk.sv */
// Purpose: port checker of the trigger sequencer
// Assumes: bound to every mts_sequencer
// Notes: single pclk domain
`timescale 1ns/100ps
module mts_seq_chk #(
	parameter int TICK_CYC = 10,
	parameter int SETUP_MS = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ext_trig_in,
	input wire logic sample_req,
	input wire logic sample_valid,
	input wire logic [31:0] sample_data,
	input wire logic message_available_flag,
	input wire logic measuring
);
	logic rd_s;
	logic clr_w;
	assign rd_s = psel && !penable && !pwrite;
	assign clr_w = psel && penable && pwrite && paddr == 8'h00 && pstrb == 4'hf && pwdata[4];
	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_req_in_run: assert property (sample_req |-> measuring)
		else $error("sample request outside a run");
	chk_req_pulse: assert property (sample_req |=> !sample_req)
		else $error("sample request longer than one cycle");
	chk_clear_idle: assert property (clr_w |=> ##[0:1] !measuring)
		else $error("device clear left the run going");
	chk_delay_max: assert property (rd_s && paddr == 8'h08 |=> prdata <= 32'h0036_ee80)
		else $error("delay above maximum");
	chk_scount_range: assert property (rd_s && paddr == 8'h0c |=> prdata inside {[32'h1:32'hc350]})
		else $error("sample count out of range");
	chk_tcount_range: assert property (rd_s && paddr == 8'h10 |=>
		prdata inside {[32'h1:32'hc350]} || prdata == 32'h7e94_f57c)
		else $error("trigger count out of range");
	chk_state_onehot: assert property (rd_s && paddr == 8'h14 |=> $onehot(prdata[3:0]))
		else $error("state field not one-hot");
	chk_busy_state: assert property (rd_s && paddr == 8'h14 |=> (prdata[3] | prdata[2]) == $past(measuring))
		else $error("busy flag disagrees with state");
	chk_flag_status: assert property (rd_s && paddr == 8'h14 |=> prdata[7] == $past(message_available_flag))
		else $error("status flag bit disagrees with pin");
	chk_src_code: assert property (rd_s && paddr == 8'h14 |=> prdata[5:4] != 2'h3)
		else $error("illegal source code");
endmodule // mts_seq_chk
bind mts_sequencer mts_seq_chk #(.TICK_CYC(TICK_CYC), .SETUP_MS(SETUP_MS)) mts_seq_chk_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.ext_trig_in(ext_trig_in), .sample_req(sample_req), .sample_valid(sample_valid),
	.sample_data(sample_data), .message_available_flag(message_available_flag), .measuring(measuring));

/* mts_engine_model.sv */
// Purpose: sample engine model answering sample requests
// Assumes: one request outstanding at a time
// Notes: slow adds five cycles; data toggles when not valid
`timescale 1ns/100ps
module mts_engine_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	input wire logic sample_req,
	output logic sample_valid,
	output logic [31:0] sample_data
);
	logic [31:0] n_r;
	logic [3:0] wait_r;
	logic busy_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_r <= 1'b0;
			wait_r <= 4'h0;
			n_r <= 32'h0;
			sample_valid <= 1'b0;
			sample_data <= 32'h0;
		end else begin
			sample_valid <= 1'b0;
			// stale data never lingers
			sample_data <= ~sample_data;
			if (sample_req) begin
				busy_r <= 1'b1;
				wait_r <= slow ? 4'h5 : 4'h0;
			end else if (busy_r && wait_r != 4'h0) begin
				wait_r <= wait_r - 4'h1;
			end else if (busy_r) begin
				busy_r <= 1'b0;
				sample_valid <= 1'b1;
				sample_data <= 32'ha500_0000 + n_r;
				n_r <= n_r + 32'h1;
			end
		end
	end
endmodule // mts_engine_model

/* measurement_trigger_sequencer_bench.sv */
// Purpose: self-checking bench of the trigger sequencer
// Assumes: ticks of 10 cycles, setup of 2 ticks
// Notes: expected results queued by the driver
`timescale 1ns/100ps
module measurement_trigger_sequencer_bench;
	logic pclk, presetn, psel, penable, pwrite, ext_trig_in, sample_req, sample_valid, slow;
	logic pready, pslverr, message_available_flag, measuring;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, sample_data, rdg;
	logic [65:0] q[$];
	logic [65:0] ent;
	int n_errors, comparisons, cyc, nx, sc, tc;
	integer seed;
	mts_sequencer #(.TICK_CYC(10), .SETUP_MS(2)) mts_sequencer_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_trig_in(ext_trig_in),
		.sample_req(sample_req), .sample_valid(sample_valid), .sample_data(sample_data),
		.message_available_flag(message_available_flag), .measuring(measuring));
	mts_engine_model mts_engine_model_i (.pclk(pclk), .presetn(presetn), .slow(slow),
		.sample_req(sample_req), .sample_valid(sample_valid), .sample_data(sample_data));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [65:0] em);
		q.push_back(em);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdg = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, {33'h0, 33'h1_0000_0000});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, a, 32'h0, {1'b0, e, 1'b1, m});
	endtask
	task automatic until_st(input logic [31:0] m, input logic [31:0] v);
		do apb(1'b0, 8'h14, 32'h0, 66'h0); while ((rdg & m) !== v);
	endtask
	task automatic take;
		until_st(32'h40, 32'h40);
		rd(8'h14, 32'hc0, 32'hc0);
		rd(8'h18, 32'ha500_0000 + nx, 32'hffff_ffff);
		nx++;
	endtask
	task automatic defaults;
		rd(8'h04, 32'h0, 32'hffff_ffff);
		rd(8'h08, 32'h0, 32'hffff_ffff);
		rd(8'h0c, 32'h1, 32'hffff_ffff);
		rd(8'h10, 32'h1, 32'hffff_ffff);
	endtask
	task automatic ext_pulse;
		ext_trig_in <= 1'b1;
		repeat (3) @(posedge pclk);
		ext_trig_in <= 1'b0;
		@(posedge pclk);
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			ent = q.pop_front();
			if (ent[32:0] != 33'h0) check({pslverr, prdata} & ent[32:0], ent[65:33] & ent[32:0]);
		end
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			tally_and_finish;
		end
	end
	initial begin
		{psel, penable, pwrite, ext_trig_in, slow} = 5'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		presetn = 1'b0;
		seed = 32'h42f0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		defaults;
		rd(8'h14, 32'h01, 32'hff);
		apb(1'b0, 8'h1c, 32'h0, {33'h1_0000_0000, 33'h1_ffff_ffff});
		for (int s = 0; s < 3; s++) begin
			wr(8'h04, s);
			rd(8'h14, s << 4, 32'h30);
		end
		wr(8'h08, 32'hffff_ffff);
		rd(8'h08, 32'h0036_ee80, 32'hffff_ffff);
		wr(8'h04, 32'h1c00);
		rd(8'h08, 32'h68, 32'hffff_ffff);
		wr(8'h08, 32'h5);
		rd(8'h04, 32'h0c00, 32'hffff_ffff);
		wr(8'h0c, 32'h0);
		rd(8'h0c, 32'h1, 32'hffff_ffff);
		wr(8'h0c, 32'h0001_0000);
		rd(8'h0c, 32'hc350, 32'hffff_ffff);
		wr(8'h10, 32'hc350);
		rd(8'h10, 32'hc350, 32'hffff_ffff);
		wr(8'h04, 32'h04);
		rd(8'h10, 32'h7e94_f57c, 32'hffff_ffff);
		wr(8'h04, 32'h0);
		wr(8'h08, 32'h0);
		for (int k = 0; k < 2; k++) begin
			sc = 1 + {$random(seed)} % 3;
			tc = 1 + {$random(seed)} % 2;
			slow <= k[0];
			wr(8'h0c, sc);
			wr(8'h10, tc);
			wr(8'h00, 32'h2 << k);
			repeat (sc * tc) take;
			rd(8'h14, 32'h01, 32'hcf);
		end
		wr(8'h0c, 32'h3);
		wr(8'h10, 32'h1);
		wr(8'h08, 32'h1);
		wr(8'h00, 32'h1);
		repeat (40) rd(8'h14, 32'h0, 32'h80);
		rd(8'h14, 32'h0000_c001, 32'h000f_c0cf);
		wr(8'h00, 32'h8);
		repeat (3) take;
		rd(8'h14, 32'h01, 32'hcf);
		wr(8'h0c, 32'h1);
		wr(8'h08, 32'h0);
		for (int s = 1; s < 3; s++) begin
			wr(8'h04, s);
			if (s == 2) ext_pulse;
			wr(8'h00, 32'h2);
			if (s == 2) ext_pulse;
			repeat (40) @(posedge pclk);
			rd(8'h14, 32'h02, 32'h4f);
			if (s == 1) wr(8'h00, 32'h40);
			else ext_pulse;
			take;
		end
		wr(8'h04, 32'h9);
		wr(8'h10, 32'h3);
		wr(8'h00, 32'h40);
		take;
		rd(8'h14, 32'h01, 32'hcf);
		wr(8'h04, 32'h04);
		wr(8'h00, 32'h2);
		repeat (3) take;
		rd(8'h14, 32'h0, 32'h01);
		wr(8'h00, 32'h10);
		rd(8'h14, 32'h01, 32'h0f);
		wr(8'h00, 32'h20);
		defaults;
		tally_and_finish;
	end
endmodule // measurement_trigger_sequencer_bench
